// ==== msd_pkg.sv ====
// package: constants for the motor start command decoder
`default_nettype none
package msd_pkg;
    // stop method setting encodings (value in whole units)
    localparam logic [13:0] MSD_COAST_MIN     = 14'h0000;
    localparam logic [13:0] MSD_COAST_MAX     = 14'h0064;
    localparam logic [13:0] MSD_DIRCOAST_MIN  = 14'h03e8;
    localparam logic [13:0] MSD_DIRCOAST_MAX  = 14'h044c;
    localparam logic [13:0] MSD_DIR_DECEL     = 14'h22b8;
    localparam logic [13:0] MSD_DECEL_DEFAULT = 14'h270f;
    localparam logic [13:0] MSD_DIRCOAST_BASE = 14'h03e8;
    // terminal function code for the hold input
    localparam logic [7:0]  MSD_FUNC_HOLD     = 8'h19;
    // default terminal codes for forward and reverse
    localparam logic [7:0]  MSD_FUNC_FWD      = 8'h3c;
    localparam logic [7:0]  MSD_FUNC_REV      = 8'h3d;
    // clock rate and one-second tick
    localparam int unsigned MSD_CLK_HZ        = 250000000;
    // bus register offsets (byte addresses)
    localparam logic [3:0]  MSD_REG_STOP      = 4'h0;
    localparam logic [3:0]  MSD_REG_ASSIGN    = 4'h4;
    localparam logic [3:0]  MSD_REG_CTRL      = 4'h8;
    localparam logic [3:0]  MSD_REG_STATUS    = 4'hc;
    // stop sequence states
    typedef enum logic [1:0] {
        MSD_IDLE  = 2'b00,
        MSD_RUN   = 2'b01,
        MSD_DELAY = 2'b11,
        MSD_DECEL = 2'b10
    } msd_state_t;
endpackage
`default_nettype wire

// ==== msd_decoder.sv ====
// module: run input decoder with self-hold, stop method and register bus
`default_nettype none
// Function
// - default setting: forward alone forward, reverse alone reverse, else decelerate
// - settings 1000-1100 or 8888: forward is run, reverse is direction
// - run+direction: off/off stop, rev only stop, fwd forward, both reverse
// - settings 0-100 or 1000-1100: run removal coasts motor
// - hold input on enables self-holding; run inputs become start triggers
// - self-hold latches run on input on then off; keeps running
// - hold input going off clears latch and decelerates
// - jog active with jog enabled ignores the hold input
// - shutoff input stops output but keeps self-hold latch
// - forward only on first terminal, reverse only on second
// - settings 0-100 s: coast after that time past run removal
// - settings 9999 or 8888 decelerate on run removal; default 9999
module msd_decoder
    import msd_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = MSD_CLK_HZ
)(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        forward_run_input,
    input  wire logic        reverse_run_input,
    input  wire logic        hold_input,
    input  wire logic        jog_input,
    input  wire logic        output_shutoff_input,
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    output logic             run_out,
    output logic             reverse_out,
    output logic             decel_stop_out,
    output logic             coast_stop_out,
    output logic             output_enable_out
);

// ----------------------------------------
// state
// ----------------------------------------
typedef struct packed {
    logic [4:0]  s1;
    logic [4:0]  s2;
    logic        hold_prev;
    logic        fwd_prev;
    logic        rev_prev;
    logic        latch_run;
    logic        latch_rev;
    logic        run_prev;
    logic        rev_last;
    msd_state_t  st;
    logic [31:0] tick_cnt;
    logic [6:0]  sec_cnt;
    logic [13:0] stop_method_setting;
    logic [7:0]  first_terminal_assign_setting;
    logic [7:0]  second_terminal_assign_setting;
    logic [7:0]  last_terminal_assign_setting;
    logic        jog_enable;
    logic        ack;
    logic [31:0] rdata;
    logic        run;
    logic        rev;
    logic        decel;
    logic        coast;
    logic        oen;
} msd_s_t;

msd_s_t q_reg;
msd_s_t q_next;

// ----------------------------------------
// decode helpers
// ----------------------------------------
logic       fwd;
logic       rvs;
logic       hold;
logic       jog;
logic       shut;
logic       fwd_ok;
logic       rev_ok;
logic       dir_mode;
logic       timed_coast;
logic       hold_en;
logic       run_cmd;
logic       dir_cmd;
logic [6:0] coast_secs;
logic       tick;

// ----------------------------------------
// decode
// ----------------------------------------
always_comb
begin
    q_next = q_reg;
    fwd  = q_reg.s2[0];
    rvs  = q_reg.s2[1];
    hold = q_reg.s2[2];
    jog  = q_reg.s2[3];
    shut = q_reg.s2[4];
    fwd_ok = (q_reg.first_terminal_assign_setting == MSD_FUNC_FWD) & fwd;
    rev_ok = (q_reg.second_terminal_assign_setting == MSD_FUNC_REV) & rvs;
    dir_mode = ((q_reg.stop_method_setting >= MSD_DIRCOAST_MIN)
               & (q_reg.stop_method_setting <= MSD_DIRCOAST_MAX))
               | (q_reg.stop_method_setting == MSD_DIR_DECEL);
    timed_coast = (q_reg.stop_method_setting <= MSD_COAST_MAX)
                  | ((q_reg.stop_method_setting >= MSD_DIRCOAST_MIN)
                  & (q_reg.stop_method_setting <= MSD_DIRCOAST_MAX));
    coast_secs = (q_reg.stop_method_setting <= MSD_COAST_MAX)
                 ? q_reg.stop_method_setting[6:0]
                 : 7'(q_reg.stop_method_setting - MSD_DIRCOAST_BASE);
    hold_en = (q_reg.first_terminal_assign_setting == MSD_FUNC_HOLD)
              | (q_reg.second_terminal_assign_setting == MSD_FUNC_HOLD)
              | (q_reg.last_terminal_assign_setting == MSD_FUNC_HOLD);
    hold_en = hold_en & ~(jog & q_reg.jog_enable);

    // ----------------------------------------
    // input synchroniser
    // ----------------------------------------
    q_next.s1 = {output_shutoff_input, jog_input, hold_input,
                 reverse_run_input, forward_run_input};
    q_next.s2 = q_reg.s1;
    q_next.fwd_prev  = fwd_ok;
    q_next.rev_prev  = rev_ok;
    q_next.hold_prev = hold;

    // ----------------------------------------
    // self-hold latch
    // ----------------------------------------
    if (hold_en & hold)
    begin
        if (q_reg.fwd_prev & ~fwd_ok)
        begin
            q_next.latch_run = 1'b1;
            q_next.latch_rev = 1'b0;
        end
        if (q_reg.rev_prev & ~rev_ok)
        begin
            q_next.latch_run = 1'b1;
            q_next.latch_rev = 1'b1;
        end
    end
    if (~(hold_en & hold))
        q_next.latch_run = 1'b0;

    // ----------------------------------------
    // commands
    // ----------------------------------------
    if (hold_en & hold)
    begin
        run_cmd = q_reg.latch_run | fwd_ok | rev_ok;
        dir_cmd = rev_ok ? 1'b1 : (fwd_ok ? 1'b0 : q_reg.latch_rev);
    end
    else if (dir_mode)
    begin
        run_cmd = fwd_ok;
        dir_cmd = rev_ok;
    end
    else
    begin
        run_cmd = fwd_ok ^ rev_ok;
        dir_cmd = rev_ok;
    end

    // ----------------------------------------
    // one-second tick
    // ----------------------------------------
    tick = 1'b0;
    if (q_reg.tick_cnt >= TICK_CYCLES - 1)
    begin
        q_next.tick_cnt = '0;
        tick = 1'b1;
    end
    else
        q_next.tick_cnt = q_reg.tick_cnt + 32'h1;

    // ----------------------------------------
    // stop sequencing
    // ----------------------------------------
    q_next.run_prev = run_cmd;
    unique case (q_reg.st)
        MSD_IDLE:
        begin
            if (run_cmd)
                q_next.st = MSD_RUN;
        end
        MSD_RUN:
        begin
            q_next.rev_last = dir_cmd;
            if (~run_cmd)
            begin
                q_next.sec_cnt = '0;
                q_next.tick_cnt = '0;
                q_next.st = timed_coast ? MSD_DELAY : MSD_DECEL;
            end
        end
        MSD_DELAY:
        begin
            if (run_cmd)
                q_next.st = MSD_RUN;
            else if (q_reg.sec_cnt >= coast_secs)
                q_next.st = MSD_IDLE;
            else if (tick)
                q_next.sec_cnt = q_reg.sec_cnt + 7'h1;
        end
        MSD_DECEL:
        begin
            q_next.st = run_cmd ? MSD_RUN : MSD_IDLE;
        end
    endcase

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    q_next.run   = (q_next.st == MSD_RUN) & ~shut;
    q_next.rev   = (q_next.st == MSD_RUN) ? dir_cmd : q_reg.rev_last;
    q_next.decel = (q_next.st == MSD_DECEL) | (q_next.st == MSD_DELAY);
    q_next.coast = (q_reg.st == MSD_DELAY) & (q_next.st == MSD_IDLE);
    q_next.oen   = ~shut & (q_next.st != MSD_IDLE);

    // ----------------------------------------
    // bus request, one wait cycle
    // ----------------------------------------
    q_next.ack = 1'b0;
    if ((avs_read | avs_write) & ~q_reg.ack)
    begin
        q_next.ack = 1'b1;
        q_next.rdata = '0;
        if (~avs_write)
        begin
            unique case (avs_address)
                MSD_REG_STOP:   q_next.rdata = {18'h0, q_reg.stop_method_setting};
                MSD_REG_ASSIGN: q_next.rdata = {8'h0, q_reg.last_terminal_assign_setting,
                                                q_reg.second_terminal_assign_setting,
                                                q_reg.first_terminal_assign_setting};
                MSD_REG_CTRL:   q_next.rdata = {31'h0, q_reg.jog_enable};
                MSD_REG_STATUS: q_next.rdata = {24'h0, q_reg.st, q_reg.latch_rev,
                                                q_reg.latch_run, q_reg.coast,
                                                q_reg.decel, q_reg.rev, q_reg.run};
                default:        q_next.rdata = '0;
            endcase
        end
    end

    // ----------------------------------------
    // bus write, lands on the acknowledge edge
    // ----------------------------------------
    if (avs_write & q_reg.ack)
    begin
        unique case (avs_address)
            MSD_REG_STOP:   q_next.stop_method_setting = avs_writedata[13:0];
            MSD_REG_ASSIGN:
            begin
                q_next.first_terminal_assign_setting  = avs_writedata[7:0];
                q_next.second_terminal_assign_setting = avs_writedata[15:8];
                q_next.last_terminal_assign_setting   = avs_writedata[23:16];
            end
            MSD_REG_CTRL:   q_next.jog_enable = avs_writedata[0];
            default:        q_next.rdata = q_reg.rdata;
        endcase
    end
end

// ----------------------------------------
// registers
// ----------------------------------------
always_ff @(posedge clk)
begin
    if (!rst_n)
    begin
        q_reg <= '0;
        q_reg.stop_method_setting <= MSD_DECEL_DEFAULT;
        q_reg.first_terminal_assign_setting <= MSD_FUNC_FWD;
        q_reg.second_terminal_assign_setting <= MSD_FUNC_REV;
    end
    else
        q_reg <= q_next;
end

// ----------------------------------------
// ports
// ----------------------------------------
assign avs_readdata      = q_reg.rdata;
assign avs_waitrequest   = ~q_reg.ack;
assign run_out           = q_reg.run;
assign reverse_out       = q_reg.rev;
assign decel_stop_out    = q_reg.decel;
assign coast_stop_out    = q_reg.coast;
assign output_enable_out = q_reg.oen;

endmodule
`default_nettype wire

// ==== msd_decoder_monitor.sv ====
// checker: port assertions of the run input decoder
`default_nettype none
module msd_decoder_monitor
    import msd_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = 10
)(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic forward_run_input,
    input wire logic reverse_run_input,
    input wire logic hold_input,
    input wire logic output_shutoff_input,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic avs_waitrequest,
    input wire logic run_out,
    input wire logic reverse_out,
    input wire logic decel_stop_out,
    input wire logic coast_stop_out,
    input wire logic output_enable_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    property p_off; output_shutoff_input [*6] |-> !run_out && !output_enable_out; endproperty
    a_off: assert property (p_off) else $error("shutoff left run on");
    property p_oen; run_out |-> output_enable_out; endproperty
    a_oen: assert property (p_oen) else $error("run without output");
    property p_rst; $rose(rst_n) |-> !run_out && !output_enable_out && avs_waitrequest; endproperty
    a_rst: assert property (p_rst) else $error("outputs not cleared");
    property p_fwd;
        (forward_run_input && !reverse_run_input && !hold_input && !output_shutoff_input) [*6]
        |-> run_out && !reverse_out;
    endproperty
    a_fwd: assert property (p_fwd) else $error("forward not run");
    property p_stop; (!forward_run_input && !reverse_run_input && !hold_input) [*6] |-> !run_out; endproperty
    a_stop: assert property (p_stop) else $error("idle inputs run");
    property p_coast; coast_stop_out |=> !coast_stop_out; endproperty
    a_coast: assert property (p_coast) else $error("coast pulse long");
    property p_decel; decel_stop_out |-> !run_out; endproperty
    a_decel: assert property (p_decel) else $error("decel while run");
    property p_ack; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest; endproperty
    a_ack: assert property (p_ack) else $error("bus answer wrong");
endmodule
bind msd_decoder msd_decoder_monitor #(.TICK_CYCLES(TICK_CYCLES)) u_mon (
    .clk(clk), .rst_n(rst_n), .forward_run_input(forward_run_input),
    .reverse_run_input(reverse_run_input), .hold_input(hold_input),
    .output_shutoff_input(output_shutoff_input), .avs_read(avs_read),
    .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .run_out(run_out),
    .reverse_out(reverse_out), .decel_stop_out(decel_stop_out),
    .coast_stop_out(coast_stop_out), .output_enable_out(output_enable_out));
`default_nettype wire

// ==== msd_switch_model.sv ====
// model: switches or controller driving the run inputs
`default_nettype none
module msd_switch_model (
    input  wire logic       clk,
    input  wire logic [4:0] cmd,
    input  wire logic       pulse_rev,
    output logic      [4:0] sw
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [4:0] sw_reg = 5'h00;
    logic [2:0] cnt_reg = 3'h0;
    // opposite input pulsed on then off
    assign sw = sw_reg | {3'h0, cnt_reg != 3'h0, 1'b0};
    always_ff @(posedge clk)
    begin
        sw_reg <= cmd;
        cnt_reg <= pulse_rev ? 3'h6 : cnt_reg - {2'h0, cnt_reg != 3'h0};
    end
endmodule
`default_nettype wire

// ==== msd_decoder_tb.sv ====
// testbench: self-checking bench of the run input decoder
`default_nettype none
module msd_decoder_tb import msd_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, rst_n = 1'b0, pulse_rev = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
    logic [4:0] cmd = 5'h00, sw;
    logic [3:0] avs_address = 4'h0;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
    logic avs_waitrequest, run_out, reverse_out, decel_stop_out, coast_stop_out, output_enable_out;
    int miscompares = 0;
    int n_tests = 0;
    always #2 clk = ~clk;
    msd_switch_model u_sw (.clk(clk), .cmd(cmd), .pulse_rev(pulse_rev), .sw(sw));
    msd_decoder #(.TICK_CYCLES(10)) uut (
        .clk(clk), .rst_n(rst_n), .forward_run_input(sw[0]), .reverse_run_input(sw[1]),
        .hold_input(sw[2]), .jog_input(sw[3]), .output_shutoff_input(sw[4]),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .run_out(run_out), .reverse_out(reverse_out),
        .decel_stop_out(decel_stop_out), .coast_stop_out(coast_stop_out),
        .output_enable_out(output_enable_out));
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        n_tests++;
        if (s !== e)
        begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic test_done;
        if (miscompares == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        avs_read <= !w;
        avs_write <= w;
        avs_address <= a;
        avs_writedata <= d;
        do
            @(posedge clk);
        while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic drv(input logic [4:0] c);
        cmd <= c;
        repeat (8) @(posedge clk);
    endtask
    task automatic t_regs;
        chk("run", {31'h0, run_out}, 32'h0);
        bus(1'b0, MSD_REG_STOP, 32'h0);
        chk("stop", rd, 32'h270f);
        bus(1'b0, MSD_REG_ASSIGN, 32'h0);
        chk("assign", rd, 32'h3d3c);
        bus(1'b0, 4'h2, 32'h0);
        chk("unmapped", rd, 32'h0);
    endtask
    task automatic t_wire(input logic [31:0] s, input logic [7:0] e);
        bus(1'b1, MSD_REG_STOP, s);
        for (int i = 0; i < 4; i++)
        begin
            drv(i[4:0]);
            chk("dir", {30'h0, run_out, reverse_out & run_out}, {30'h0, e[2*i+:2]});
        end
    endtask
    task automatic t_coast(input logic [31:0] s, input int lo, input int hi);
        int n;
        logic dec;
        n = 0;
        dec = 1'b0;
        bus(1'b1, MSD_REG_STOP, s);
        drv(5'h01);
        cmd <= 5'h00;
        while (coast_stop_out !== 1'b1 && n < 200)
        begin
            @(posedge clk);
            dec = dec | decel_stop_out;
            n++;
        end
        chk("coast", {31'h0, n >= lo && n <= hi}, 32'h1);
        chk("decel", {31'h0, dec}, 32'h1);
    endtask
    task automatic t_hold;
        bus(1'b1, MSD_REG_STOP, 32'h270f);
        bus(1'b1, MSD_REG_ASSIGN, 32'h193d3c);
        bus(1'b0, MSD_REG_ASSIGN, 32'h0);
        chk("assign_wr", rd, 32'h193d3c);
        drv(5'h04);
        drv(5'h05);
        drv(5'h04);
        chk("latch", {30'h0, run_out, reverse_out}, 32'h2);
        pulse_rev <= 1'b1;
        @(posedge clk);
        pulse_rev <= 1'b0;
        repeat (14) @(posedge clk);
        chk("flip", {30'h0, run_out, reverse_out}, 32'h3);
        drv(5'h14);
        chk("shut", {30'h0, run_out, output_enable_out}, 32'h0);
        drv(5'h04);
        chk("keep", {31'h0, run_out}, 32'h1);
        drv(5'h00);
        chk("unhold", {31'h0, run_out}, 32'h0);
        bus(1'b1, MSD_REG_CTRL, 32'h1);
        drv(5'h0c);
        drv(5'h0d);
        drv(5'h0c);
        chk("jog", {31'h0, run_out}, 32'h0);
        bus(1'b1, MSD_REG_ASSIGN, 32'h3c);
        drv(5'h02);
        chk("revterm", {31'h0, run_out}, 32'h0);
    endtask
    initial
    begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        t_regs;
        t_wire(32'h270f, 8'h38);
        t_wire(32'h22b8, 8'hc8);
        t_wire(32'h3e8, 8'hc8);
        t_coast(32'h2, 21, 28);
        t_coast(32'h3e8, 2, 8);
        t_hold;
        test_done;
    end
    initial
    begin
        repeat (5000) @(posedge clk);
        miscompares++;
        test_done;
    end
endmodule
`default_nettype wire
